/* include/ldf_defines.svh */
`ifndef LDF_DEFINES_SVH
`define LDF_DEFINES_SVH

`define LDF_WORDS      5120
`define LDF_ADDR_W     13
`define LDF_DATA_W     8
`define LDF_ADDR_INIT  13'h0000
`define LDF_ADDR_LAST  13'h13ff
`define LDF_WORD_W     21
`define LDF_BUF_DEPTH  2

`define LDF_CTL_W      6
`define LDF_CTL_WCK    0
`define LDF_CTL_WEN    1
`define LDF_CTL_WRST   2
`define LDF_CTL_RCK    3
`define LDF_CTL_REN    4
`define LDF_CTL_RRST   5
`define LDF_CTL_RESET  6'h3f

`define LDF_DATA_RESET 8'h00
`define LDF_OE_N_RESET 1'b1

`endif

/* include/ldf_pkg.sv */
`include "ldf_defines.svh"

package ldf_pkg;

  typedef logic [`LDF_DATA_W-1:0] ldf_byte_type;
  typedef logic [`LDF_ADDR_W-1:0] ldf_addr_type;
  typedef logic [`LDF_CTL_W-1:0]  ldf_ctl_type;

  typedef struct packed {
    ldf_addr_type addr;
    ldf_byte_type data;
  } ldf_word_type;

  typedef logic [`LDF_WORDS-1:0][`LDF_DATA_W-1:0] ldf_line_type;

endpackage

/* include/ldf_stream_if.sv */
`include "ldf_defines.svh"

interface ldf_stream_if #(
  parameter int WIDTH = `LDF_WORD_W
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

/* src/ldf_skid_buffer.sv */
`include "ldf_defines.svh"

module ldf_skid_buffer #(
  parameter int WIDTH = `LDF_WORD_W,
  parameter int DEPTH = `LDF_BUF_DEPTH
) (
  input  wire logic   mclk,
  input  wire logic   rstn,
  ldf_stream_if.sink   fill,
  ldf_stream_if.source drain
);
  import ldf_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] IDX_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PW-1:0]               wr_idx;
    logic [PW-1:0]               rd_idx;
    logic [CW-1:0]               count;
  } ldf_buf_state_type;

  ldf_buf_state_type q;
  ldf_buf_state_type d;
  logic              push;
  logic              pop;

  function automatic logic [PW-1:0] ldf_bump(input logic [PW-1:0] idx);
    ldf_bump = (idx == IDX_LAST) ? '0 : idx + PW'(1);
  endfunction

  assign fill.ready  = (q.count != CNT_FULL);
  assign drain.valid = (q.count != '0);
  assign drain.data  = q.slot[q.rd_idx];
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.slot[q.wr_idx] = fill.data;
      d.wr_idx         = ldf_bump(q.wr_idx);
    end
    if (pop)
    begin
      d.rd_idx = ldf_bump(q.rd_idx);
    end
    if (push && !pop)
    begin
      d.count = q.count + CW'(1);
    end
    else if (pop && !push)
    begin
      d.count = q.count - CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule

/* src/ldf_top.sv */
// Overview of operation
// - Two line memories of 5120 bytes each give a one-line and a two-line delay.
// - A write clock rise with write enable low stores the input byte and advances the first write address.
// - With write enable high no byte is stored and the first write address holds.
// - A write clock rise with write reset low returns the first write address to zero.
// - A read clock rise with read enable low puts the first and second memory words on the two outputs.
// - Each enabled read advances both read addresses together.
// - Each enabled read also copies the new one-line byte into the second memory and advances its write address.
// - With read enable high no read happens and both read addresses hold.
// - With read enable high at a read clock rise both output enables go high; the output buses keep their last byte.
// - With read enable high the second memory is not written and its write address holds.
// - A read clock rise with read reset low clears the first read address and both second memory addresses.
// - Write side and read side run independently on unrelated clocks.
`include "ldf_defines.svh"

module ldf_top (
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic                  write_clock,
  input  wire logic                  write_enable_low,
  input  wire logic                  write_reset_low,
  input  wire ldf_pkg::ldf_byte_type write_data_in,
  input  wire logic                  read_clock,
  input  wire logic                  read_enable_low,
  input  wire logic                  read_reset_low,
  output wire ldf_pkg::ldf_byte_type one_line_delay_out,
  output wire logic                  one_line_delay_oe_n,
  output wire ldf_pkg::ldf_byte_type two_line_delay_out,
  output wire logic                  two_line_delay_oe_n,
  output wire logic                  write_ready
);
  import ldf_pkg::*;

  typedef struct packed {
    ldf_byte_type data_s1;
    ldf_byte_type data_s2;
    ldf_ctl_type  ctl_s1;
    ldf_ctl_type  ctl_s2;
    logic         wck_prev;
    logic         rck_prev;
    ldf_addr_type wr_addr1;
    ldf_addr_type rd_addr1;
    ldf_addr_type wr_addr2;
    ldf_addr_type rd_addr2;
    ldf_byte_type out1;
    ldf_byte_type out2;
    logic         out_oe_n;
    ldf_line_type line1;
    ldf_line_type line2;
  } ldf_state_type;

  localparam ldf_state_type STATE_RESET = '{
    data_s1:  `LDF_DATA_RESET,
    data_s2:  `LDF_DATA_RESET,
    ctl_s1:   `LDF_CTL_RESET,
    ctl_s2:   `LDF_CTL_RESET,
    wck_prev: 1'b1,
    rck_prev: 1'b1,
    wr_addr1: `LDF_ADDR_INIT,
    rd_addr1: `LDF_ADDR_INIT,
    wr_addr2: `LDF_ADDR_INIT,
    rd_addr2: `LDF_ADDR_INIT,
    out1:     `LDF_DATA_RESET,
    out2:     `LDF_DATA_RESET,
    out_oe_n: `LDF_OE_N_RESET,
    line1:    '0,
    line2:    '0
  };

  ldf_state_type q;
  ldf_state_type d;
  ldf_word_type  push_word;
  ldf_word_type  drain_word;
  logic          wr_edge;
  logic          rd_edge;
  logic          wr_rst_hit;
  logic          wr_take;
  logic          rd_rst_hit;
  logic          rd_take;
  ldf_byte_type  line1_word;

  ldf_stream_if #(.WIDTH(`LDF_WORD_W)) fill_if ();
  ldf_stream_if #(.WIDTH(`LDF_WORD_W)) drain_if ();

  function automatic ldf_addr_type ldf_next_addr(input ldf_addr_type a);
    ldf_next_addr = (a == `LDF_ADDR_LAST) ? `LDF_ADDR_INIT : a + 13'h0001;
  endfunction

  // Pin clocks are sampled as levels; edges come from the second and third stages only
  assign wr_edge    = q.ctl_s2[`LDF_CTL_WCK] & ~q.wck_prev;
  assign rd_edge    = q.ctl_s2[`LDF_CTL_RCK] & ~q.rck_prev;
  assign wr_rst_hit = wr_edge & ~q.ctl_s2[`LDF_CTL_WRST];
  assign wr_take    = wr_edge & q.ctl_s2[`LDF_CTL_WRST] & ~q.ctl_s2[`LDF_CTL_WEN];
  assign rd_rst_hit = rd_edge & ~q.ctl_s2[`LDF_CTL_RRST];
  assign rd_take    = rd_edge & q.ctl_s2[`LDF_CTL_RRST] & ~q.ctl_s2[`LDF_CTL_REN];
  assign line1_word = q.line1[q.rd_addr1];

  assign push_word.addr = q.wr_addr1;
  assign push_word.data = q.data_s2;
  assign fill_if.valid  = wr_take;
  assign fill_if.data   = push_word;
  // A read owns the first memory for its cycle, so the pending write waits in the buffer
  assign drain_if.ready = ~rd_take;
  assign drain_word     = drain_if.data;

  ldf_skid_buffer #(
    .WIDTH (`LDF_WORD_W),
    .DEPTH (`LDF_BUF_DEPTH)
  ) u_wr_buffer (
    .mclk  (mclk),
    .rstn  (rstn),
    .fill  (fill_if.sink),
    .drain (drain_if.source)
  );

  always_comb
  begin
    d = q;
    d.data_s1                = write_data_in;
    d.data_s2                = q.data_s1;
    d.ctl_s1[`LDF_CTL_WCK]   = write_clock;
    d.ctl_s1[`LDF_CTL_WEN]   = write_enable_low;
    d.ctl_s1[`LDF_CTL_WRST]  = write_reset_low;
    d.ctl_s1[`LDF_CTL_RCK]   = read_clock;
    d.ctl_s1[`LDF_CTL_REN]   = read_enable_low;
    d.ctl_s1[`LDF_CTL_RRST]  = read_reset_low;
    d.ctl_s2                 = q.ctl_s1;
    d.wck_prev               = q.ctl_s2[`LDF_CTL_WCK];
    d.rck_prev               = q.ctl_s2[`LDF_CTL_RCK];

    // Write side: reset wins over a write on the same clock edge
    if (wr_rst_hit)
    begin
      d.wr_addr1 = `LDF_ADDR_INIT;
    end
    else if (wr_take && fill_if.ready)
    begin
      d.wr_addr1 = ldf_next_addr(q.wr_addr1);
    end

    if (drain_if.valid && drain_if.ready)
    begin
      d.line1[drain_word.addr] = drain_word.data;
    end

    // Read side
    if (rd_edge)
    begin
      d.out_oe_n = q.ctl_s2[`LDF_CTL_REN];
    end
    if (rd_rst_hit)
    begin
      d.rd_addr1 = `LDF_ADDR_INIT;
      d.wr_addr2 = `LDF_ADDR_INIT;
      d.rd_addr2 = `LDF_ADDR_INIT;
    end
    else if (rd_take)
    begin
      d.out1                = line1_word;
      d.out2                = q.line2[q.rd_addr2];
      d.line2[q.wr_addr2]   = line1_word;
      d.wr_addr2            = ldf_next_addr(q.wr_addr2);
      d.rd_addr1            = ldf_next_addr(q.rd_addr1);
      d.rd_addr2            = ldf_next_addr(q.rd_addr2);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      q <= STATE_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  assign one_line_delay_out  = q.out1;
  assign two_line_delay_out  = q.out2;
  assign one_line_delay_oe_n = q.out_oe_n;
  assign two_line_delay_oe_n = q.out_oe_n;
  // A low ready means the buffer is full and a write edge now is dropped; at most one write per three mclk cycles keeps it high
  assign write_ready         = fill_if.ready;

endmodule

/* test/ldf_top_properties.sv */
module ldf_top_checker (
  input wire logic                  mclk,
  input wire logic                  rstn,
  input wire logic                  read_clock,
  input wire logic                  read_enable_low,
  input wire ldf_pkg::ldf_byte_type one_line_delay_out,
  input wire logic                  one_line_delay_oe_n,
  input wire ldf_pkg::ldf_byte_type two_line_delay_out,
  input wire logic                  two_line_delay_oe_n,
  input wire logic                  write_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldf_pkg::*;
  // Cycles since the read pin clock moved, and since read enable went high
  logic [3:0] rc_q;
  logic [3:0] eh_q;
  logic       rp_q;
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      rc_q <= 4'h0;
      eh_q <= 4'h0;
      rp_q <= 1'b1;
    end
    else
    begin
      rp_q <= read_clock;
      rc_q <= (read_clock != rp_q) ? 4'h0 : rc_q + {3'h0, rc_q != 4'hf};
      eh_q <= !read_enable_low ? 4'h0 : eh_q + {3'h0, eh_q != 4'hf};
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  a_oe_pair: assert property (one_line_delay_oe_n == two_line_delay_oe_n)
    else $error("output enables differ");
  a_reset_vals: assert property ($rose(rstn) |-> one_line_delay_oe_n
    && one_line_delay_out == 8'h00 && write_ready) else $error("bad reset state");
  // Eight quiet cycles cover the pin synchroniser and edge detector
  a_idle_hold: assert property (rc_q >= 4'h8 |-> $stable(one_line_delay_out)
    && $stable(two_line_delay_out) && $stable(one_line_delay_oe_n)) else $error("output moved");
  a_off_hold: assert property (eh_q >= 4'h8 |-> $stable(one_line_delay_out)
    && $stable(two_line_delay_out)) else $error("read while disabled");
  a_no_drive: assert property (eh_q >= 4'h8 |-> !$fell(one_line_delay_oe_n))
    else $error("driven while disabled");
  a_drive_on: assert property (($rose(read_clock) && !read_enable_low)
    ##1 !read_enable_low [*3] |-> ##[0:4] !one_line_delay_oe_n) else $error("not driven");
  a_drive_off: assert property (($rose(read_clock) && read_enable_low)
    ##1 read_enable_low [*3] |-> ##[0:4] one_line_delay_oe_n) else $error("not released");
  a_ready_kept: assert property (write_ready)
    else $error("write byte refused");
  c_read_on: cover property (!one_line_delay_oe_n && $changed(one_line_delay_out));
  c_read_off: cover property ($rose(one_line_delay_oe_n));
  c_second: cover property ($changed(two_line_delay_out));
endmodule

bind ldf_top ldf_top_checker chk_u (.mclk, .rstn, .read_clock, .read_enable_low,
  .one_line_delay_out, .one_line_delay_oe_n, .two_line_delay_out, .two_line_delay_oe_n,
  .write_ready);

/* test/ldf_line_agent.sv */
module ldf_line_agent (
  input  wire logic                  mclk,
  output logic                       write_clock,
  output logic                       write_enable_low,
  output logic                       write_reset_low,
  output ldf_pkg::ldf_byte_type      write_data_in,
  output logic                       read_clock,
  output logic                       read_enable_low,
  output logic                       read_reset_low,
  input  wire ldf_pkg::ldf_byte_type one_line_delay_out,
  input  wire logic                  one_line_delay_oe_n,
  input  wire ldf_pkg::ldf_byte_type two_line_delay_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldf_pkg::*;
  initial
  begin
    {write_clock, write_enable_low, write_reset_low} = 3'h7;
    {read_clock, read_enable_low, read_reset_low} = 3'h7;
    write_data_in = 8'h00;
  end
  // Pin clock low phases of three cycles; idle gaps stay far below the hold limit
  task automatic wr(input ldf_byte_type d, input logic en_n, input logic rs_n);
    @(posedge mclk);
    #1;
    write_clock = 1'b0;
    write_enable_low = en_n;
    write_reset_low = rs_n;
    write_data_in = d;
    repeat (3) @(posedge mclk);
    #1;
    write_clock = 1'b1;
    repeat (2) @(posedge mclk);
  endtask
  // Released outputs read as high impedance, never as the last byte
  task automatic rd(input logic en_n, input logic rs_n, output ldf_byte_type q1,
                    output ldf_byte_type q2, output logic oe);
    @(posedge mclk);
    #1;
    read_clock = 1'b0;
    read_enable_low = en_n;
    read_reset_low = rs_n;
    repeat (3) @(posedge mclk);
    #1;
    read_clock = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    oe = one_line_delay_oe_n;
    q1 = oe ? 8'hzz : one_line_delay_out;
    q2 = oe ? 8'hzz : two_line_delay_out;
  endtask
endmodule

/* test/ldf_top_test.sv */
module ldf_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ldf_pkg::*;
  logic         mclk = 1'b0;
  logic         rstn = 1'b0;
  logic         write_clock, write_enable_low, write_reset_low;
  logic         read_clock, read_enable_low, read_reset_low;
  logic         one_line_delay_oe_n, two_line_delay_oe_n, write_ready, oe;
  ldf_byte_type write_data_in, one_line_delay_out, two_line_delay_out, q1, q2;
  int           fails = 0;
  int           n_compared = 0;
  int           cyc = 0;
  ldf_top dut_u (.mclk, .rstn, .write_clock, .write_enable_low, .write_reset_low,
    .write_data_in, .read_clock, .read_enable_low, .read_reset_low, .one_line_delay_out,
    .one_line_delay_oe_n, .two_line_delay_out, .two_line_delay_oe_n, .write_ready);
  ldf_line_agent agent_u (.mclk, .write_clock, .write_enable_low, .write_reset_low,
    .write_data_in, .read_clock, .read_enable_low, .read_reset_low, .one_line_delay_out,
    .one_line_delay_oe_n, .two_line_delay_out);
  always #5 mclk = ~mclk;
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 50000)
    begin
      fails = fails + 1;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic get(input logic [7:0] e1, input logic [7:0] e2);
    agent_u.rd(1'b0, 1'b1, q1, q2, oe);
    chk("one_line", q1, e1);
    chk("two_line", q2, e2);
    chk("oe_n", {7'h0, oe}, 8'h00);
  endtask
  // Pin resets come first so that no stale address is relied on
  task automatic resets();
    agent_u.wr(8'h00, 1'b1, 1'b0);
    agent_u.rd(1'b1, 1'b0, q1, q2, oe);
  endtask
  task automatic t_order();
    resets();
    agent_u.wr(8'h11, 1'b0, 1'b1);
    agent_u.wr(8'h22, 1'b1, 1'b1);
    agent_u.wr(8'h33, 1'b0, 1'b1);
    get(8'h11, 8'h00);
    agent_u.rd(1'b1, 1'b1, q1, q2, oe);
    chk("oe_off", {7'h0, oe}, 8'h01);
    get(8'h33, 8'h00);
    agent_u.rd(1'b1, 1'b0, q1, q2, oe);
    get(8'h11, 8'h11);
    get(8'h33, 8'h33);
    $display("order test done");
  endtask
  function automatic logic [7:0] pat(input int k);
    return k[7:0] ^ {3'h0, k[12:8]};
  endfunction
  task automatic t_wrap();
    agent_u.wr(8'h00, 1'b1, 1'b0);
    agent_u.wr(8'ha5, 1'b0, 1'b1);
    agent_u.rd(1'b1, 1'b0, q1, q2, oe);
    get(8'ha5, 8'h11);
    agent_u.wr(8'h00, 1'b1, 1'b0);
    for (int k = 0; k < 5122; k++)
      agent_u.wr(pat(k), 1'b0, 1'b1);
    agent_u.rd(1'b1, 1'b0, q1, q2, oe);
    get(pat(5120), 8'ha5);
    get(pat(5121), 8'h33);
    $display("wrap test done");
  endtask
  initial
  begin
    repeat (2) @(posedge mclk);
    #1;
    rstn = 1'b1;
    chk("oe_rst", {7'h0, one_line_delay_oe_n}, 8'h01);
    chk("rdy_rst", {7'h0, write_ready}, 8'h01);
    $display("reset test done");
    t_order();
    t_wrap();
    finish_test();
  end
endmodule
